// *** common/pss_map.vh ***
`ifndef PSS_MAP_VH
`define PSS_MAP_VH
// =====================================================
// Widths
`define PSS_IDX_W       6
`define PSS_TOT_W       7
`define PSS_PARAM_W     32
`define PSS_SET_DEPTH   64
// =====================================================
// Set bounds
`define PSS_SET_MAX     7'h40
`define PSS_SET_FIRST   6'h00
`define PSS_IDX_ONE     6'h01
// =====================================================
// Reset values
`define PSS_PARAM_RST   32'h00000000
// =====================================================
// One-hot states
`define PSS_ST_W        6
`define PSS_ST_OFF      6'h01
`define PSS_ST_LOAD_RD  6'h02
`define PSS_ST_LOAD_WR  6'h04
`define PSS_ST_WAIT     6'h08
`define PSS_ST_BUSY     6'h10
`define PSS_ST_RESTORE  6'h20
`endif

// *** dv/pss_sequencer_checker.sv ***
`include "pss_map.vh"
// ==========
// Port checker
module pss_sequencer_checker
(
	// Clock and reset
	input wire logic                    ref_clk,
	input wire logic                    rst_n,
	// Host and frames
	input wire logic                    sequencer_on,
	input wire logic                    frame_trig,
	input wire logic                    frame_done,
	// Outputs
	input wire logic                    acq_start_q,
	input wire logic [`PSS_PARAM_W-1:0] active_param_q,
	input wire logic                    wait_trig,
	input wire logic                    trig_dropped_q,
	input wire logic [`PSS_IDX_W-1:0]   cur_idx_q,
	input wire logic                    seq_running
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Set load: two quiet cycles
	sequence load_s;
		!wait_trig ##1 !wait_trig ##1 wait_trig;
	endsequence
	// Restore, then plain mode
	sequence restore_s;
		!wait_trig ##1 (wait_trig && !seq_running && cur_idx_q == `PSS_SET_FIRST);
	endsequence
	trig_take_a: assert property (
		frame_trig && wait_trig |=> acq_start_q && !wait_trig) else $error("trigger not taken");
	trig_drop_a: assert property (
		frame_trig && !wait_trig |=> trig_dropped_q && !acq_start_q) else $error("trigger not dropped");
	enable_load_a: assert property (
		$rose(seq_running) |-> load_s ##0 cur_idx_q == `PSS_SET_FIRST) else $error("bad enable load");
	idx_step_a: assert property (
		seq_running && $past(seq_running) && $changed(cur_idx_q)
		|-> cur_idx_q == `PSS_SET_FIRST || cur_idx_q == $past(cur_idx_q) + `PSS_IDX_ONE) else $error("bad step");
	idx_load_a: assert property (
		$changed(cur_idx_q) && seq_running |-> !$past(wait_trig) && !$past(wait_trig, 2)) else $error("index moved unloaded");
	acq_hold_a: assert property (
		acq_start_q |-> $stable(active_param_q) && $stable(cur_idx_q)) else $error("set moved at start");
	frame_end_a: assert property (
		frame_done && seq_running && sequencer_on && !wait_trig |=> wait_trig) else $error("no wait after frame");
	disable_end_a: assert property (
		frame_done && seq_running && !sequencer_on && !wait_trig |=> restore_s) else $error("bad disable");
endmodule
bind pss_sequencer pss_sequencer_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .sequencer_on(sequencer_on),
	.frame_trig(frame_trig), .frame_done(frame_done), .acq_start_q(acq_start_q), .active_param_q(active_param_q),
	.wait_trig(wait_trig), .trig_dropped_q(trig_dropped_q), .cur_idx_q(cur_idx_q), .seq_running(seq_running));

// *** dv/pss_sequencer_tb_top.sv ***
`include "pss_map.vh"
// ==========
// Bench top
module pss_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0, rst_n = 1'b0, sequencer_on = 1'b0, step_cmd = 1'b0, rew_cmd = 1'b0;
	logic        host_we = 1'b0, store_we = 1'b0, fire = 1'b0, bad = 1'b0;
	logic [6:0]  set_total = 7'h06;
	logic [31:0] host_param = 32'h0, store_data = 32'h0;
	logic [5:0]  store_idx = 6'h0;
	wire         frame_trig, frame_done, acq_start_q, wait_trig, trig_dropped_q, seq_running;
	wire [31:0]  active_param_q;
	wire [5:0]   cur_idx_q;
	int          mismatches = 0, n_compared = 0;
	always #5 ref_clk = ~ref_clk;
	pss_sequencer dut (.ref_clk(ref_clk), .rst_n(rst_n), .sequencer_on(sequencer_on),
		.soft_step_forward_cmd(step_cmd), .soft_rewind_cmd(rew_cmd), .set_total(set_total),
		.host_param_we(host_we), .host_param(host_param), .store_we(store_we), .store_idx(store_idx),
		.store_data(store_data), .frame_trig(frame_trig), .frame_done(frame_done), .acq_start_q(acq_start_q),
		.active_param_q(active_param_q), .wait_trig(wait_trig), .trig_dropped_q(trig_dropped_q),
		.cur_idx_q(cur_idx_q), .seq_running(seq_running));
	pss_trig_src u_src (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .bad(bad), .wait_trig(wait_trig),
		.acq_start_q(acq_start_q), .frame_trig(frame_trig), .frame_done(frame_done));
	// Stored set contents, distinct per index
	function logic [31:0] sd(input logic [5:0] i);
		sd = {26'h1234567, i};
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Bounded wait for waiting status
	task settle;
		int i;
		i = 0;
		do
		begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		while (wait_trig !== 1'b1 && i < 20);
		chk("wait_trig", wait_trig, 1'b1);
	endtask
	// One frame; cmd 1 step, 2 rewind, 3 disable while busy
	task frame(input logic [5:0] idx, input int cmd);
		int i;
		@(posedge ref_clk) fire <= 1'b1;
		@(posedge ref_clk) fire <= 1'b0;
		i = 0;
		while (acq_start_q !== 1'b1 && i < 20)
		begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		chk("acq seen", acq_start_q, 1'b1);
		chk("acq idx", cur_idx_q, idx);
		chk("acq set", active_param_q, sd(idx));
		@(posedge ref_clk)
		begin
			step_cmd <= (cmd == 1);
			rew_cmd <= (cmd == 2);
			sequencer_on <= (cmd != 3);
		end
		@(posedge ref_clk)
		begin
			step_cmd <= 1'b0;
			rew_cmd <= 1'b0;
		end
		i = 0;
		while (frame_done !== 1'b1 && i < 20)
		begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		chk("frame end", frame_done, 1'b1);
		chk("busy idx", cur_idx_q, idx);
	endtask
	// Plain trigger with the sequencer off keeps host values
	task plain;
		@(posedge ref_clk) fire <= 1'b1;
		@(posedge ref_clk) fire <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("plain acq", acq_start_q, 1'b1);
		chk("plain set", active_param_q, 32'hC0DE0001);
		settle;
		chk("plain run", seq_running, 1'b0);
	endtask
	// Command applied after the frame
	task pend(input logic [5:0] exp);
		repeat (2) @(posedge ref_clk);
		settle;
		chk("pend idx", cur_idx_q, exp);
		chk("pend set", active_param_q, sd(exp));
	endtask
	// Step while waiting; bad trigger lands in the load
	task step(input logic [5:0] exp, input logic drop);
		@(posedge ref_clk) step_cmd <= 1'b1;
		@(posedge ref_clk)
		begin
			step_cmd <= 1'b0;
			bad <= drop;
		end
		@(posedge ref_clk) bad <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("dropped", trig_dropped_q, drop);
		chk("no acq", acq_start_q, 1'b0);
		settle;
		chk("step idx", cur_idx_q, exp);
		chk("step set", active_param_q, sd(exp));
	endtask
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
			@(posedge ref_clk)
			begin
				store_we <= 1'b1;
				store_idx <= 6'(i);
				store_data <= sd(6'(i));
			end
		@(posedge ref_clk)
		begin
			store_we <= 1'b0;
			host_we <= 1'b1;
			host_param <= 32'hC0DE0001;
		end
		@(posedge ref_clk)
		begin
			host_we <= 1'b0;
			sequencer_on <= 1'b1;
		end
		settle;
		chk("on idx", cur_idx_q, 6'h00);
		chk("on set", active_param_q, sd(6'h00));
		chk("on run", seq_running, 1'b1);
		frame(6'h00, 0);
		for (int k = 1; k <= 6; k++)
			step(6'(k % 6), 1'b0);
		frame(6'h00, 1);
		pend(6'h01);
		step(6'h02, 1'b1);
		frame(6'h02, 2);
		pend(6'h00);
		frame(6'h00, 3);
		settle;
		chk("restored", active_param_q, 32'hC0DE0001);
		chk("stopped", seq_running, 1'b0);
		plain;
		stop_test;
	end
	// Hang guard
	initial
	begin
		#20000;
		mismatches++;
		stop_test;
	end
endmodule

// *** dv/pss_trig_src.sv ***
// ==========
// Trigger source and frame engine
module pss_trig_src
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Bench requests
	input  wire logic fire,
	input  wire logic bad,
	// Device side
	input  wire logic wait_trig,
	input  wire logic acq_start_q,
	output logic      frame_trig,
	output logic      frame_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q; // Frame length count
	// Fire only while waiting; bad fires anyway
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frame_trig <= 1'b0;
			frame_done <= 1'b0;
			cnt_q      <= 4'h0;
		end
		else
		begin
			frame_trig <= (fire && wait_trig && !frame_trig) || bad;
			frame_done <= (cnt_q == 4'h1);
			cnt_q      <= acq_start_q ? 4'h5 : ((cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0);
		end
	end
endmodule

// *** hw/pss_sequencer.v ***
`include "pss_map.vh"
// Functional notes
// - Step only on software step command
// - Rewind only on software rewind command
// - Command latency unbounded; frames may intervene
// - Enable loads set zero into active
// - Trigger acquires with active set, unchanged
// - Step loads next higher set
// - Step after last set wraps to zero
// - Rewind loads set zero always
// - Waiting status drops during set load
// - Triggers outside waiting status are discarded
// - Disable mid-frame finishes frame first
// - Disable restores pre-enable active values
// - Up to 64 sets, indexed from zero
module pss_sequencer
(
	// Clock and reset
	input  wire                      ref_clk,
	input  wire                      rst_n,
	// Host control
	input  wire                      sequencer_on,
	input  wire                      soft_step_forward_cmd,
	input  wire                      soft_rewind_cmd,
	input  wire [`PSS_TOT_W-1:0]     set_total,
	// Host access to active set while sequencer is off
	input  wire                      host_param_we,
	input  wire [`PSS_PARAM_W-1:0]   host_param,
	// Host storing of sets
	input  wire                      store_we,
	input  wire [`PSS_IDX_W-1:0]     store_idx,
	input  wire [`PSS_PARAM_W-1:0]   store_data,
	// Trigger source
	input  wire                      frame_trig,
	// Frame engine
	input  wire                      frame_done,
	output reg                       acq_start_q,
	output reg  [`PSS_PARAM_W-1:0]   active_param_q,
	// Status
	output wire                      wait_trig,
	output reg                       trig_dropped_q,
	output reg  [`PSS_IDX_W-1:0]     cur_idx_q,
	output wire                      seq_running
);

	// =====================================================
	// State
	reg [`PSS_ST_W-1:0]      state_q;        // One-hot state
	reg [`PSS_ST_W-1:0]      state_d;
	reg                      run_q;          // Sequencer cycling
	reg                      run_d;
	reg                      step_pend_q;    // Held step command
	reg                      step_pend_d;
	reg                      rew_pend_q;     // Held rewind command
	reg                      rew_pend_d;
	reg [`PSS_IDX_W-1:0]     load_idx_q;     // Set being loaded
	reg [`PSS_IDX_W-1:0]     load_idx_d;
	reg [`PSS_IDX_W-1:0]     cur_idx_d;
	reg [`PSS_PARAM_W-1:0]   saved_q;        // Pre-enable active values
	reg [`PSS_PARAM_W-1:0]   saved_d;
	reg [`PSS_PARAM_W-1:0]   active_d;
	reg                      acq_start_d;
	reg                      trig_dropped_d;
	reg                      rd_en;          // Set store read strobe
	wire [`PSS_PARAM_W-1:0]  rd_data;        // Set store read data
	wire [`PSS_IDX_W-1:0]    last_idx;       // Highest index in cycle
	wire [`PSS_IDX_W-1:0]    next_idx;       // Index after current
	reg  [`PSS_TOT_W-1:0]    total_c;        // Clamped total

	// =====================================================
	// Clamp total to 1..64 so a bad setting cannot leave range
	always @*
	begin
		if (set_total == {`PSS_TOT_W{1'b0}})
		begin
			total_c = {{(`PSS_TOT_W-1){1'b0}}, 1'b1};
		end
		else if (set_total > `PSS_SET_MAX)
		begin
			total_c = `PSS_SET_MAX;
		end
		else
		begin
			total_c = set_total;
		end
	end

	// Last index is total minus one; wrap after it
	assign last_idx = total_c[`PSS_IDX_W-1:0] - `PSS_IDX_ONE;
	assign next_idx = (cur_idx_q == last_idx) ? `PSS_SET_FIRST : (cur_idx_q + `PSS_IDX_ONE);

	// Status: low during loads, restore and frames
	assign wait_trig   = (state_q == `PSS_ST_WAIT) | (state_q == `PSS_ST_OFF);
	assign seq_running = run_q;

	// =====================================================
	// Set store
	pss_set_store u_store
	(
		.ref_clk (ref_clk),
		.wr_en   (store_we),
		.wr_idx  (store_idx),
		.wr_data (store_data),
		.rd_en   (rd_en),
		.rd_idx  (load_idx_q),
		.rd_data (rd_data)
	);

	// =====================================================
	// Next-state logic
	always @*
	begin
		state_d        = state_q;
		run_d          = run_q;
		step_pend_d    = step_pend_q;
		rew_pend_d     = rew_pend_q;
		load_idx_d     = load_idx_q;
		cur_idx_d      = cur_idx_q;
		saved_d        = saved_q;
		active_d       = active_param_q;
		acq_start_d    = 1'b0;
		trig_dropped_d = 1'b0;
		rd_en          = 1'b0;
		// Commands only matter while cycling; new ones win over consumption below
		case (state_q)
			`PSS_ST_OFF:
			begin
				// Plain acquisition, host may edit active set
				if (frame_trig)
				begin
					acq_start_d = 1'b1;
					state_d     = `PSS_ST_BUSY;
				end
				else if (sequencer_on)
				begin
					// Keep values for restore, then start cycle at set zero
					saved_d    = active_param_q;
					run_d      = 1'b1;
					load_idx_d = `PSS_SET_FIRST;
					state_d    = `PSS_ST_LOAD_RD;
				end
				else if (host_param_we)
				begin
					active_d = host_param;
				end
			end
			`PSS_ST_LOAD_RD:
			begin
				// Fetch stored set
				rd_en   = 1'b1;
				state_d = `PSS_ST_LOAD_WR;
				if (frame_trig)
				begin
					trig_dropped_d = 1'b1;
				end
			end
			`PSS_ST_LOAD_WR:
			begin
				// Copy into active set, then wait again
				active_d  = rd_data;
				cur_idx_d = load_idx_q;
				state_d   = `PSS_ST_WAIT;
				if (frame_trig)
				begin
					trig_dropped_d = 1'b1;
				end
			end
			`PSS_ST_WAIT:
			begin
				// Trigger first; commands stay pending across frames
				if (frame_trig)
				begin
					acq_start_d = 1'b1;
					state_d     = `PSS_ST_BUSY;
				end
				else if (!sequencer_on)
				begin
					state_d = `PSS_ST_RESTORE;
				end
				else if (rew_pend_q)
				begin
					// Rewind beats step and absorbs it
					rew_pend_d  = 1'b0;
					step_pend_d = 1'b0;
					load_idx_d  = `PSS_SET_FIRST;
					state_d     = `PSS_ST_LOAD_RD;
				end
				else if (step_pend_q)
				begin
					step_pend_d = 1'b0;
					load_idx_d  = next_idx;
					state_d     = `PSS_ST_LOAD_RD;
				end
			end
			`PSS_ST_BUSY:
			begin
				// Exposure, readout and transmission; never load here
				if (frame_trig)
				begin
					trig_dropped_d = 1'b1;
				end
				if (frame_done)
				begin
					if (run_q && !sequencer_on)
					begin
						state_d = `PSS_ST_RESTORE;
					end
					else if (run_q)
					begin
						state_d = `PSS_ST_WAIT;
					end
					else
					begin
						state_d = `PSS_ST_OFF;
					end
				end
			end
			`PSS_ST_RESTORE:
			begin
				// Stop cycling and put back pre-enable values
				active_d    = saved_q;
				run_d       = 1'b0;
				step_pend_d = 1'b0;
				rew_pend_d  = 1'b0;
				cur_idx_d   = `PSS_SET_FIRST;
				state_d     = `PSS_ST_OFF;
				if (frame_trig)
				begin
					trig_dropped_d = 1'b1;
				end
			end
			default:
			begin
				state_d = `PSS_ST_OFF;
			end
		endcase
		// Capture new commands last so an arrival beats a same-cycle consume
		if (run_d && soft_rewind_cmd)
		begin
			rew_pend_d = 1'b1;
		end
		if (run_d && soft_step_forward_cmd)
		begin
			step_pend_d = 1'b1;
		end
	end

	// =====================================================
	// State registers
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q        <= `PSS_ST_OFF;
			run_q          <= 1'b0;
			step_pend_q    <= 1'b0;
			rew_pend_q     <= 1'b0;
			load_idx_q     <= `PSS_SET_FIRST;
			cur_idx_q      <= `PSS_SET_FIRST;
			saved_q        <= `PSS_PARAM_RST;
			active_param_q <= `PSS_PARAM_RST;
			acq_start_q    <= 1'b0;
			trig_dropped_q <= 1'b0;
		end
		else
		begin
			state_q        <= state_d;
			run_q          <= run_d;
			step_pend_q    <= step_pend_d;
			rew_pend_q     <= rew_pend_d;
			load_idx_q     <= load_idx_d;
			cur_idx_q      <= cur_idx_d;
			saved_q        <= saved_d;
			active_param_q <= active_d;
			acq_start_q    <= acq_start_d;
			trig_dropped_q <= trig_dropped_d;
		end
	end

endmodule

// *** hw/pss_set_store.v ***
`include "pss_map.vh"
// =====================================================
// Stored parameter sets, one write port, registered read
module pss_set_store
(
	// Clock
	input  wire                      ref_clk,
	// Write side
	input  wire                      wr_en,
	input  wire [`PSS_IDX_W-1:0]     wr_idx,
	input  wire [`PSS_PARAM_W-1:0]   wr_data,
	// Read side, data valid one cycle after rd_en
	input  wire                      rd_en,
	input  wire [`PSS_IDX_W-1:0]     rd_idx,
	output reg  [`PSS_PARAM_W-1:0]   rd_data
);

	// Set memory, no reset so it maps onto RAM
	reg [`PSS_PARAM_W-1:0] mem [0:`PSS_SET_DEPTH-1];

	// =====================================================
	// Write and read ports
	always @(posedge ref_clk)
	begin
		if (wr_en)
		begin
			mem[wr_idx] <= wr_data;
		end
		if (rd_en)
		begin
			rd_data <= mem[rd_idx];
		end
	end

endmodule
